// >>> verilog/laser_seq_pkg.sv
// Shared constants, register map and state encoding of the laser sequencer
package laser_seq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_SECOND = 1_000_000_000;
  localparam int CYCLES_PER_SECOND = NS_PER_SECOND / CLK_PERIOD_NS;
  localparam int INIT_CLEAR_NS = 160;
  localparam int INIT_CLEAR_CYCLES = INIT_CLEAR_NS / CLK_PERIOD_NS;
  localparam int INIT_CNT_W = 5;
  localparam int SYNC_STAGES_W = 8;

  // ****************************************
  // Register port and map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] EVAC_TIME_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // Control fields
  localparam int CTRL_SOLID_BIT = 0;
  localparam int CTRL_EVAC_EN_BIT = 1;
  localparam int CTRL_FAULT_CLR_BIT = 2;
  localparam logic CTRL_SOLID_RESET = 1'h0;
  localparam logic CTRL_EVAC_EN_RESET = 1'h1;

  // Evacuation time in seconds
  localparam int EVAC_TIME_W = 15;
  localparam logic [14:0] EVAC_TIME_MIN = 15'h0258;
  localparam logic [14:0] EVAC_TIME_MAX = 15'h7FFF;
  localparam logic [14:0] EVAC_TIME_RESET = 15'h0384;

  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IDLE_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_COOL_BIT = 6;
  localparam int STAT_ARMED_BIT = 7;
  localparam int STAT_REFDIS_BIT = 8;
  localparam int STAT_BEAM_BIT = 9;
  localparam int STAT_FAULT_BIT = 10;
  localparam int STAT_EVAC_BIT = 11;

  // ****************************************
  // Sequencer states, Gray along the path
  // ****************************************
  typedef enum logic [2:0] {
    ST_POWER_CLEAR = 3'h0,
    ST_IDLE = 3'h1,
    ST_GAS_CTRL = 3'h3,
    ST_ARMED = 3'h2,
    ST_REF_DISCHARGE = 3'h6,
    ST_BEAM = 3'h7,
    ST_EVACUATE = 3'h5,
    ST_PURGE = 3'h4
  } seq_state_type;

endpackage

// >>> verilog/input_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Asynchronous levels in, synchronous levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_regs_type;

  sync_regs_type s;
  sync_regs_type next_s;

  // First stage feeds only the second
  always_comb begin
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  // Register both stages
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;

endmodule
`default_nettype wire

// >>> verilog/evac_timer.sv
// Seconds countdown for the evacuation step, with its own prescaler
`timescale 1ns/1ps
`default_nettype none
module evac_timer #(
  parameter int CYCLES_PER_SECOND = laser_seq_pkg::CYCLES_PER_SECOND,
  parameter int TIME_W = laser_seq_pkg::EVAC_TIME_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Start pulse with duration in seconds
  input wire logic start_in,
  input wire logic [TIME_W-1:0] seconds_in,
  // Status
  output logic busy_out,
  output logic done_out
);

  localparam int PRE_W = $clog2(CYCLES_PER_SECOND + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_SECOND - 1);

  typedef struct packed {
    logic [PRE_W-1:0] prescale;
    logic [TIME_W-1:0] seconds;
    logic busy;
    logic done;
  } timer_regs_type;

  timer_regs_type s;
  timer_regs_type next_s;

  // One-second enable from the prescaler drives the countdown
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start_in) begin
      next_s.busy = 1'b1;
      next_s.seconds = seconds_in;
      next_s.prescale = '0;
    end else if (s.busy) begin
      if (s.prescale == PRE_LAST) begin
        next_s.prescale = '0;
        if (s.seconds <= TIME_W'(1)) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.seconds = s.seconds - TIME_W'(1);
        end
      end else begin
        next_s.prescale = s.prescale + PRE_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_out = s.busy;
  assign done_out = s.done;

endmodule
`default_nettype wire

// >>> verilog/laser_oscillator_start_stop_sequencer.sv
// Start and stop sequencer of the laser oscillator with its register port
`timescale 1ns/1ps
`default_nettype none
module laser_oscillator_start_stop_sequencer #(
  parameter int CYCLES_PER_SECOND = laser_seq_pkg::CYCLES_PER_SECOND
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Handshake from the machine side
  input wire logic osc_start_req_in,
  input wire logic discharge_start_req_in,
  input wire logic coolant_ready_in,
  // Oscillator process feedback and safety
  input wire logic gas_pressure_done_in,
  input wire logic comp_done_in,
  input wire logic purge_done_in,
  input wire logic laser_alarm_in,
  input wire logic emergency_stop_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Handshake to the machine side
  output logic idle_safe_flag_out,
  output logic transition_busy_out,
  output logic coolant_request_out,
  output logic discharge_armed_out,
  output logic ref_discharge_active_out,
  output logic beam_ready_out,
  output logic chiller_fault_out,
  // Oscillator actuators
  output logic gas_supply_valve_out,
  output logic exhaust_valve_out,
  output logic gas_control_out,
  output logic purge_out,
  output logic rf_supply_on_out,
  output logic comp_measure_out
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    laser_seq_pkg::seq_state_type state;
    logic [laser_seq_pkg::INIT_CNT_W-1:0] init_cnt;
    logic osc_prev;
    logic dis_prev;
    logic cool_seen;
    logic chiller_fault;
    logic idle;
    logic busy;
    logic cool_req;
    logic armed;
    logic refdis;
    logic beam;
    logic rf_on;
    logic gas_valve;
    logic exhaust;
    logic gas_ctrl;
    logic purge;
    logic comp_meas;
    logic evac_timed;
    logic evac_start;
    logic solid;
    logic evac_en;
    logic [14:0] evac_time;
    logic [31:0] rdata;
  } seq_regs_type;

  localparam seq_regs_type RESET_REGS = '{
    state: laser_seq_pkg::ST_POWER_CLEAR,
    solid: laser_seq_pkg::CTRL_SOLID_RESET,
    evac_en: laser_seq_pkg::CTRL_EVAC_EN_RESET,
    evac_time: laser_seq_pkg::EVAC_TIME_RESET,
    default: '0
  };
  localparam logic [4:0] INIT_LAST =
    5'(laser_seq_pkg::INIT_CLEAR_CYCLES - 1);

  seq_regs_type s;
  seq_regs_type next_s;

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [7:0] sync_vec;
  logic osc;
  logic dis;
  logic cool;
  logic gas_done;
  logic comp_done;
  logic purge_done;
  logic laser_alarm;
  logic estop;
  logic timer_done;
  logic timer_busy;

  // All handshake, feedback and safety pins pass two flip-flops first; the register port is used directly
  input_sync #(.WIDTH(laser_seq_pkg::SYNC_STAGES_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in({emergency_stop_in, laser_alarm_in, purge_done_in,
               comp_done_in, gas_pressure_done_in, coolant_ready_in,
               discharge_start_req_in, osc_start_req_in}),
    .sync_out(sync_vec)
  );

  assign {estop, laser_alarm, purge_done, comp_done, gas_done, cool, dis,
          osc} = sync_vec;

  // Evacuation countdown in seconds
  evac_timer #(
    .CYCLES_PER_SECOND(CYCLES_PER_SECOND),
    .TIME_W(laser_seq_pkg::EVAC_TIME_W)
  ) u_evac_timer (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .start_in(s.evac_start),
    .seconds_in(s.evac_time),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Keep the evacuation time inside its valid range
  function automatic logic [14:0] clamp_evac(input logic [31:0] v);
    if (v < {17'h00000, laser_seq_pkg::EVAC_TIME_MIN}) begin
      return laser_seq_pkg::EVAC_TIME_MIN;
    end else if (v > {17'h00000, laser_seq_pkg::EVAC_TIME_MAX}) begin
      return laser_seq_pkg::EVAC_TIME_MAX;
    end else begin
      return v[14:0];
    end
  endfunction

  // Discharge off, then gas stop path or direct stop for solid state
  function automatic seq_regs_type begin_stop(input seq_regs_type x);
    seq_regs_type y;
    y = x;
    y.armed = 1'b0;
    y.beam = 1'b0;
    y.rf_on = 1'b0;
    y.refdis = 1'b0;
    y.comp_meas = 1'b0;
    y.gas_ctrl = 1'b0;
    y.gas_valve = 1'b0;
    if (x.solid) begin
      y.cool_req = 1'b0;
      y.busy = 1'b0;
      y.idle = 1'b1;
      y.state = laser_seq_pkg::ST_IDLE;
    end else begin
      y.busy = 1'b1;
      y.exhaust = 1'b1;
      y.evac_timed = x.evac_en;
      y.evac_start = x.evac_en;
      y.state = laser_seq_pkg::ST_EVACUATE;
    end
    return y;
  endfunction

  logic osc_rise;
  logic dis_rise;
  logic fault_set;
  assign osc_rise = osc && !s.osc_prev;
  assign dis_rise = dis && !s.dis_prev;
  assign fault_set = s.cool_req && s.cool_seen && !cool;

  // ****************************************
  // Sequencer and registers
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.osc_prev = osc;
    next_s.dis_prev = dis;
    next_s.evac_start = 1'b0;
    next_s.rdata = '0;

    // Register writes
    if (reg_write_in) begin
      if (reg_addr_in == laser_seq_pkg::CTRL_ADDR) begin
        next_s.solid = reg_wdata_in[laser_seq_pkg::CTRL_SOLID_BIT];
        next_s.evac_en = reg_wdata_in[laser_seq_pkg::CTRL_EVAC_EN_BIT];
        if (reg_wdata_in[laser_seq_pkg::CTRL_FAULT_CLR_BIT]) begin
          next_s.chiller_fault = 1'b0;
        end
      end else if (reg_addr_in == laser_seq_pkg::EVAC_TIME_ADDR) begin
        next_s.evac_time = clamp_evac(reg_wdata_in);
      end
    end

    // Chiller watch, set wins over a clear in the same cycle
    next_s.cool_seen = s.cool_req && (s.cool_seen || cool);
    if (fault_set) begin
      next_s.chiller_fault = 1'b1;
    end

    // Beam is withdrawn on any alarm or stop
    if (laser_alarm || s.chiller_fault || estop) begin
      next_s.beam = 1'b0;
    end

    case (s.state)
      laser_seq_pkg::ST_POWER_CLEAR: begin
        next_s.init_cnt = s.init_cnt + 5'h01;
        if (s.init_cnt == INIT_LAST) begin
          next_s.idle = 1'b1;
          next_s.state = laser_seq_pkg::ST_IDLE;
        end
      end
      laser_seq_pkg::ST_IDLE: begin
        if (osc_rise && s.idle) begin
          next_s.idle = 1'b0;
          next_s.busy = 1'b1;
          next_s.cool_req = 1'b1;
          next_s.gas_ctrl = !s.solid;
          next_s.gas_valve = !s.solid;
          next_s.state = laser_seq_pkg::ST_GAS_CTRL;
        end
      end
      laser_seq_pkg::ST_GAS_CTRL: begin
        if (!osc) begin
          next_s = begin_stop(next_s);
        end else if (s.solid || gas_done) begin
          next_s.gas_ctrl = 1'b0;
          next_s.busy = 1'b0;
          next_s.armed = 1'b1;
          next_s.state = laser_seq_pkg::ST_ARMED;
        end
      end
      laser_seq_pkg::ST_ARMED: begin
        if (!osc) begin
          next_s = begin_stop(next_s);
        end else if (dis_rise && s.armed) begin
          next_s.rf_on = 1'b1;
          next_s.armed = 1'b0;
          next_s.refdis = 1'b1;
          next_s.comp_meas = 1'b1;
          next_s.state = laser_seq_pkg::ST_REF_DISCHARGE;
        end
      end
      laser_seq_pkg::ST_REF_DISCHARGE,
      laser_seq_pkg::ST_BEAM: begin
        if (!osc) begin
          next_s = begin_stop(next_s);
        end else if (!dis || estop) begin
          next_s.rf_on = 1'b0;
          next_s.refdis = 1'b0;
          next_s.comp_meas = 1'b0;
          next_s.beam = 1'b0;
          next_s.armed = 1'b1;
          next_s.state = laser_seq_pkg::ST_ARMED;
        end else if (s.state == laser_seq_pkg::ST_REF_DISCHARGE &&
                     comp_done) begin
          next_s.refdis = 1'b0;
          next_s.comp_meas = 1'b0;
          next_s.beam = !(laser_alarm || s.chiller_fault);
          next_s.state = laser_seq_pkg::ST_BEAM;
        end
      end
      laser_seq_pkg::ST_EVACUATE: begin
        if (!s.evac_timed || timer_done) begin
          next_s.exhaust = 1'b0;
          next_s.purge = 1'b1;
          next_s.gas_valve = 1'b1;
          next_s.state = laser_seq_pkg::ST_PURGE;
        end
      end
      laser_seq_pkg::ST_PURGE: begin
        if (purge_done) begin
          next_s.purge = 1'b0;
          next_s.gas_valve = 1'b0;
          next_s.cool_req = 1'b0;
          next_s.busy = 1'b0;
          next_s.idle = 1'b1;
          next_s.state = laser_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s = RESET_REGS;
      end
    endcase

    // Register reads, data valid the next cycle only
    if (reg_read_in) begin
      if (reg_addr_in == laser_seq_pkg::CTRL_ADDR) begin
        next_s.rdata[laser_seq_pkg::CTRL_SOLID_BIT] = s.solid;
        next_s.rdata[laser_seq_pkg::CTRL_EVAC_EN_BIT] = s.evac_en;
      end else if (reg_addr_in == laser_seq_pkg::EVAC_TIME_ADDR) begin
        next_s.rdata[14:0] = s.evac_time;
      end else if (reg_addr_in == laser_seq_pkg::STATUS_ADDR) begin
        next_s.rdata[2:0] = s.state;
        next_s.rdata[laser_seq_pkg::STAT_IDLE_BIT] = s.idle;
        next_s.rdata[laser_seq_pkg::STAT_BUSY_BIT] = s.busy;
        next_s.rdata[laser_seq_pkg::STAT_COOL_BIT] = s.cool_req;
        next_s.rdata[laser_seq_pkg::STAT_ARMED_BIT] = s.armed;
        next_s.rdata[laser_seq_pkg::STAT_REFDIS_BIT] = s.refdis;
        next_s.rdata[laser_seq_pkg::STAT_BEAM_BIT] = s.beam;
        next_s.rdata[laser_seq_pkg::STAT_FAULT_BIT] = s.chiller_fault;
        next_s.rdata[laser_seq_pkg::STAT_EVAC_BIT] = timer_busy;
      end
    end
  end

  // State register, power-on clear at reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= RESET_REGS;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state record
  assign reg_rdata_out = s.rdata;
  assign idle_safe_flag_out = s.idle;
  assign transition_busy_out = s.busy;
  assign coolant_request_out = s.cool_req;
  assign discharge_armed_out = s.armed;
  assign ref_discharge_active_out = s.refdis;
  assign beam_ready_out = s.beam;
  assign chiller_fault_out = s.chiller_fault;
  assign gas_supply_valve_out = s.gas_valve;
  assign exhaust_valve_out = s.exhaust;
  assign gas_control_out = s.gas_ctrl;
  assign purge_out = s.purge;
  assign rf_supply_on_out = s.rf_on;
  assign comp_measure_out = s.comp_meas;

  // ****************************************
  // Checks
  // ****************************************
  localparam int INIT_BOUND = 16;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  property p_idle_after_clear;
    s.state == laser_seq_pkg::ST_POWER_CLEAR |-> ##[1:INIT_BOUND] s.idle;
  endproperty
  a_idle_after_clear: assert property (p_idle_after_clear)
    else $error("idle flag not raised after power-on clear");

  property p_start_only_idle;
    $rose(s.cool_req) |-> $past(s.idle) && $past(osc_rise);
  endproperty
  a_start_only_idle: assert property (p_start_only_idle)
    else $error("start sequence began outside idle");

  property p_start_flags;
    s.state == laser_seq_pkg::ST_IDLE && osc_rise
      |=> !s.idle && s.busy && s.cool_req;
  endproperty
  a_start_flags: assert property (p_start_flags)
    else $error("start flags wrong after start request");

  property p_chiller_fault;
    fault_set |=> s.chiller_fault;
  endproperty
  a_chiller_fault: assert property (p_chiller_fault)
    else $error("chiller fault not raised");

  property p_gas_done;
    s.state == laser_seq_pkg::ST_GAS_CTRL && osc && (s.solid || gas_done)
      |=> !s.busy && s.armed;
  endproperty
  a_gas_done: assert property (p_gas_done)
    else $error("armed not raised after gas control");

  property p_discharge_accept;
    $rose(s.refdis) |-> s.rf_on && !s.armed && $past(s.armed);
  endproperty
  a_discharge_accept: assert property (p_discharge_accept)
    else $error("reference discharge without armed state");

  property p_discharge_drop;
    s.state == laser_seq_pkg::ST_BEAM && osc && !dis
      |=> !s.beam && s.armed && !s.rf_on;
  endproperty
  a_discharge_drop: assert property (p_discharge_drop)
    else $error("discharge not stopped on request drop");

  property p_stop_from_armed;
    s.state == laser_seq_pkg::ST_ARMED && !osc && !s.solid
      |=> !s.armed && s.busy && s.exhaust && !s.gas_valve;
  endproperty
  a_stop_from_armed: assert property (p_stop_from_armed)
    else $error("stop sequence not entered from armed");

  property p_evac_hold;
    s.state == laser_seq_pkg::ST_EVACUATE && s.evac_timed && !timer_done
      |=> s.state == laser_seq_pkg::ST_EVACUATE && s.exhaust;
  endproperty
  a_evac_hold: assert property (p_evac_hold)
    else $error("evacuation left before its time");

  property p_purge_done;
    s.state == laser_seq_pkg::ST_PURGE && purge_done
      |=> s.idle && !s.cool_req && !s.busy;
  endproperty
  a_purge_done: assert property (p_purge_done)
    else $error("idle not restored after purge");

  property p_beam_drop;
    s.beam && (laser_alarm || estop || !dis || !osc) |=> !s.beam;
  endproperty
  a_beam_drop: assert property (p_beam_drop)
    else $error("beam ready not withdrawn");

endmodule
`default_nettype wire

// >>> test/chiller_model.sv
// Machine-side chiller model answering the coolant request
`timescale 1ns/1ps
`default_nettype none
module chiller_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Request and forced failure
  input wire logic coolant_request_in,
  input wire logic fail_in,
  // Answer
  output logic coolant_ready_out
);
  logic [1:0] dly;
  // Ready follows the request after a pump start delay
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dly <= 2'h0;
    end else begin
      dly <= {dly[0], coolant_request_in & !fail_in};
    end
  end
  assign coolant_ready_out = dly[1];
endmodule
`default_nettype wire

// >>> test/tb_laser_oscillator_start_stop_sequencer.sv
// Self-checking testbench of the laser oscillator sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_laser_oscillator_start_stop_sequencer;
  logic clk_sys_in, reset_n_in, osc_start_req_in, discharge_start_req_in;
  logic coolant_ready_in, gas_pressure_done_in, comp_done_in, purge_done_in;
  logic laser_alarm_in, emergency_stop_in, reg_write_in, reg_read_in, fail;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic idle_safe_flag_out, transition_busy_out, coolant_request_out;
  logic discharge_armed_out, ref_discharge_active_out, beam_ready_out;
  logic chiller_fault_out, gas_supply_valve_out, exhaust_valve_out;
  logic gas_control_out, purge_out, rf_supply_on_out, comp_measure_out;
  logic [5:0] hs;
  int error_cnt = 0;
  int num_checks = 0;
  // Handshake outputs gathered: idle busy cool armed refdis beam
  assign hs = {idle_safe_flag_out, transition_busy_out, coolant_request_out,
    discharge_armed_out, ref_discharge_active_out, beam_ready_out};
  laser_oscillator_start_stop_sequencer #(.CYCLES_PER_SECOND(10)) DUT (
    .clk_sys_in, .reset_n_in, .osc_start_req_in, .discharge_start_req_in,
    .coolant_ready_in, .gas_pressure_done_in, .comp_done_in, .purge_done_in,
    .laser_alarm_in, .emergency_stop_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .idle_safe_flag_out,
    .transition_busy_out, .coolant_request_out, .discharge_armed_out,
    .ref_discharge_active_out, .beam_ready_out, .chiller_fault_out,
    .gas_supply_valve_out, .exhaust_valve_out, .gas_control_out, .purge_out,
    .rf_supply_on_out, .comp_measure_out);
  chiller_model u_chiller (.clk_sys_in, .reset_n_in,
    .coolant_request_in(coolant_request_out), .fail_in(fail),
    .coolant_ready_out(coolant_ready_in));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1;
    chk(name, exp, reg_rdata_out);
    cyc(1);
    chk(name, 32'h0, reg_rdata_out);
  endtask
  task automatic results();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Drives the request pins, then waits n cycles before the checks
  task automatic pins(logic o, logic d, int n);
    @(posedge clk_sys_in);
    osc_start_req_in <= o;
    discharge_start_req_in <= d;
    cyc(n);
  endtask
  // Reaches beam ready from armed
  task automatic to_beam();
    pins(1'b1, 1'b1, 4);
    chk("refdis", 6'h0A, hs);
    chk("rf", 1'b1, rf_supply_on_out);
    chk("comp", 1'b1, comp_measure_out);
    comp_done_in <= 1'b1;
    cyc(4);
    comp_done_in <= 1'b0;
    chk("beam", 6'h09, hs);
    chk("comp_off", 1'b0, comp_measure_out);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power();
    cyc(10);
    chk("early", 6'h00, hs);
    cyc(8);
    chk("idle", 6'h20, hs);
    rd(8'h00, 32'h2, "ctrl");
    rd(8'h04, 32'h384, "evac");
    rd(8'h08, 32'h11, "status");
    rd(8'hF0, 32'h0, "unmapped");
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h258, "clamp");
  endtask
  task automatic t_start();
    pins(1'b0, 1'b1, 4);
    chk("dis_idle", 6'h20, hs);
    pins(1'b1, 1'b0, 4);
    chk("start", 6'h18, hs);
    chk("gas", 1'b1, gas_control_out);
    chk("gasv", 1'b1, gas_supply_valve_out);
    pins(1'b1, 1'b1, 4);
    chk("dis_gas", 6'h18, hs);
    pins(1'b1, 1'b0, 1);
    gas_pressure_done_in <= 1'b1;
    cyc(4);
    gas_pressure_done_in <= 1'b0;
    chk("armed", 6'h0C, hs);
  endtask
  task automatic t_discharge();
    to_beam();
    laser_alarm_in <= 1'b1;
    cyc(4);
    chk("alarm", 6'h08, hs);
    laser_alarm_in <= 1'b0;
    pins(1'b1, 1'b0, 4);
    chk("dis_off", 6'h0C, hs);
    to_beam();
    emergency_stop_in <= 1'b1;
    cyc(4);
    chk("estop", 6'h0C, hs);
    emergency_stop_in <= 1'b0;
    pins(1'b1, 1'b0, 4);
  endtask
  task automatic t_fault();
    fail <= 1'b1;
    cyc(6);
    chk("fault", 1'b1, chiller_fault_out);
    fail <= 1'b0;
    cyc(4);
    wr(8'h00, 32'h6);
    cyc(1);
    chk("fault_clr", 1'b0, chiller_fault_out);
  endtask
  task automatic t_stop();
    int n;
    n = 0;
    pins(1'b0, 1'b0, 4);
    chk("stop", 6'h18, hs);
    chk("exh", 1'b1, exhaust_valve_out);
    chk("gasv_shut", 1'b0, gas_supply_valve_out);
    while (exhaust_valve_out === 1'b1 && n < 7000) begin
      cyc(1);
      n++;
    end
    chk("evac_len", 1'b1, n >= 5990 && n <= 6010);
    chk("purge", 1'b1, purge_out);
    chk("gasv_fill", 1'b1, gas_supply_valve_out);
    purge_done_in <= 1'b1;
    cyc(4);
    purge_done_in <= 1'b0;
    chk("purged", 6'h20, hs);
    chk("power_off", 1'b1, idle_safe_flag_out);
  endtask
  // Untimed stop straight from beam on the gas variant
  task automatic t_quick();
    wr(8'h00, 32'h0);
    pins(1'b1, 1'b0, 4);
    gas_pressure_done_in <= 1'b1;
    cyc(4);
    gas_pressure_done_in <= 1'b0;
    chk("q_armed", 6'h0C, hs);
    to_beam();
    pins(1'b0, 1'b1, 4);
    chk("q_stop", 6'h18, hs);
    chk("q_rf", 1'b0, rf_supply_on_out);
    chk("q_exh", 1'b0, exhaust_valve_out);
    chk("q_purge", 1'b1, purge_out);
    purge_done_in <= 1'b1;
    cyc(4);
    purge_done_in <= 1'b0;
    chk("q_idle", 6'h20, hs);
  endtask
  task automatic t_solid();
    wr(8'h00, 32'h3);
    pins(1'b1, 1'b0, 6);
    chk("s_armed", 6'h0C, hs);
    to_beam();
    pins(1'b0, 1'b1, 6);
    chk("s_stop", 6'h20, hs);
    chk("s_rf", 1'b0, rf_supply_on_out);
    pins(1'b0, 1'b0, 2);
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Main sequence
  initial begin
    {reset_n_in, osc_start_req_in, discharge_start_req_in} = 3'h0;
    {gas_pressure_done_in, comp_done_in, purge_done_in} = 3'h0;
    {laser_alarm_in, emergency_stop_in, reg_write_in, reg_read_in} = 4'h0;
    fail = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_power();
    t_start();
    t_discharge();
    t_fault();
    t_stop();
    t_quick();
    t_solid();
    results();
  end
endmodule
`default_nettype wire
